// *** logic/srt_timer_group.sv ***
// eight independent 16-bit reload timers with an apb register port
//
// Functional notes
// - eight independent 16-bit counters with reload
// - mode from mode register bits 0, 1
// - timer mode counts down, reloads on underflow
// - timer divides source by n plus one
// - count start flag runs or halts timer
// - timer mode requests interrupt on underflow
// - write while stopped loads reload and counter
// - write while running loads reload only
// - reading timer register returns live count
// - gate option: input pin level gates counting
// - timer mode pins: port/gate, port/pulse
// - pulse output toggles on each underflow
// - all eight timers single-phase, no two-phase
// - event counts chosen pin edge or overflows
// - direction from software or output pin
// - up divides FFFF-n+1, down n+1
// - no free-run: reload on over/underflow
// - free-run: counter wraps without reload
// - event mode interrupt on over/underflow
// - event pulse output toggles on wrap
// - event output pin: port, pulse or direction
`timescale 1ns/1ps
module srt_timer_group
  import srt_pkg::*;
#(
  parameter int NUM_TIMERS = SRT_NUM_TIMERS
) (
  input  wire logic                  CLK_I,
  input  wire logic                  RESET_I,
  input  wire logic                  PSEL_I,
  input  wire logic                  PENABLE_I,
  input  wire logic                  PWRITE_I,
  input  wire logic [SRT_ADDR_W-1:0] PADDR_I,
  input  wire logic [31:0]           PWDATA_I,
  output logic      [31:0]           PRDATA_O,
  output logic                       PREADY_O,
  output logic                       PSLVERR_O,
  input  wire logic                  SUBCLOCK_I,
  input  wire logic                  SECOND_GROUP_TIMER_TWO_OVF_I,
  input  wire logic                  SECOND_GROUP_TIMER_FIVE_OVF_I,
  input  wire logic [NUM_TIMERS-1:0] TIMER_INPUT_PIN_I,
  input  wire logic [NUM_TIMERS-1:0] TIMER_OUTPUT_PIN_I,
  output logic      [NUM_TIMERS-1:0] TIMER_OUTPUT_PIN_O,
  output logic      [NUM_TIMERS-1:0] TIMER_OUTPUT_PIN_OE_O,
  output logic      [NUM_TIMERS-1:0] TIMER_IRQ_O
);

  // address decode shared by the read and write paths
  function automatic srt_dec_s srt_decode(input logic [SRT_ADDR_W-1:0] a);
    srt_dec_s   d;
    logic [11:0] rel;
    d = '0;
    rel = a - SRT_MODE_BASE;
    d.hit_start = (a == SRT_START_OFS);
    d.hit_dir   = (a == SRT_DIR_OFS);
    if (a >= SRT_MODE_BASE &&
        a < SRT_MODE_BASE + SRT_TIMER_STRIDE * 12'(NUM_TIMERS) &&
        rel[1:0] == 2'h0) begin
      d.idx       = rel[5:3];
      d.hit_mode  = (rel[2] == 1'b0);
      d.hit_count = (rel[2] == 1'b1);
    end
    return d;
  endfunction

  // input synchronisers; stage one feeds stage two only
  logic [NUM_TIMERS-1:0] in_s1_r, in_s2_r, in_prev_r;
  logic [NUM_TIMERS-1:0] out_s1_r, out_s2_r;
  logic                  sub_s1_r, sub_s2_r, sub_prev_r;

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      in_s1_r    <= '0;
      in_s2_r    <= '0;
      in_prev_r  <= '0;
      out_s1_r   <= '0;
      out_s2_r   <= '0;
      sub_s1_r   <= 1'b0;
      sub_s2_r   <= 1'b0;
      sub_prev_r <= 1'b0;
    end else begin
      in_s1_r    <= TIMER_INPUT_PIN_I;
      in_s2_r    <= in_s1_r;
      in_prev_r  <= in_s2_r;
      out_s1_r   <= TIMER_OUTPUT_PIN_I;
      out_s2_r   <= out_s1_r;
      sub_s1_r   <= SUBCLOCK_I;
      sub_s2_r   <= sub_s1_r;
      sub_prev_r <= sub_s2_r;
    end
  end

  // shared prescalers, free-running so every timer sees the same phase
  logic [4:0] pre_r, pre_nxt;
  logic [4:0] sub_r, sub_nxt;
  logic       sub_rise;
  logic [3:0] src_tick;

  always_comb begin
    pre_nxt     = pre_r + 5'h01;
    sub_rise    = sub_s2_r & ~sub_prev_r;
    sub_nxt     = sub_rise ? sub_r + 5'h01 : sub_r;
    src_tick[0] = 1'b1;
    src_tick[1] = ((pre_r & SRT_DIV8_MASK) == SRT_DIV8_MASK);
    src_tick[2] = (pre_r == SRT_DIV32_LAST);
    src_tick[3] = sub_rise && (sub_r == SRT_DIV32_LAST);
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      pre_r <= '0;
      sub_r <= '0;
    end else begin
      pre_r <= pre_nxt;
      sub_r <= sub_nxt;
    end
  end

  // register file and counters
  logic [NUM_TIMERS-1:0] start_r, start_nxt;
  logic [NUM_TIMERS-1:0] dir_r, dir_nxt;
  srt_mode_s             mode_r   [NUM_TIMERS];
  srt_mode_s             mode_nxt [NUM_TIMERS];
  logic [SRT_CNT_W-1:0]  cnt_r    [NUM_TIMERS];
  logic [SRT_CNT_W-1:0]  cnt_nxt  [NUM_TIMERS];
  logic [SRT_CNT_W-1:0]  rld_r    [NUM_TIMERS];
  logic [SRT_CNT_W-1:0]  rld_nxt  [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] wrap_r, wrap_nxt;
  logic [NUM_TIMERS-1:0] pout_r, pout_nxt;
  logic [NUM_TIMERS-1:0] oe_r, oe_nxt;
  logic [31:0]           rdata_r, rdata_nxt;
  logic                  err_r, err_nxt;

  srt_dec_s              dec;
  logic                  wr_en;
  logic                  tick;
  logic                  up;
  logic                  limit;
  logic                  wr_cnt;
  logic [SRT_CNT_W-1:0]  rld_eff;

  // per-timer counting and register writes
  always_comb begin
    dec       = srt_decode(PADDR_I);
    wr_en     = PSEL_I & PENABLE_I & PWRITE_I;
    start_nxt = start_r;
    dir_nxt   = dir_r;
    wrap_nxt  = '0;
    pout_nxt  = pout_r;
    oe_nxt    = '0;
    tick      = 1'b0;
    up        = 1'b0;
    limit     = 1'b0;
    wr_cnt    = 1'b0;
    rld_eff   = '0;
    if (wr_en && dec.hit_start) begin
      start_nxt = PWDATA_I[NUM_TIMERS-1:0];
    end
    if (wr_en && dec.hit_dir) begin
      dir_nxt = PWDATA_I[NUM_TIMERS-1:0];
    end
    for (int i = 0; i < NUM_TIMERS; i++) begin
      mode_nxt[i] = mode_r[i];
      cnt_nxt[i]  = cnt_r[i];
      rld_nxt[i]  = rld_r[i];
      if (wr_en && dec.hit_mode && dec.idx == 3'(i)) begin
        mode_nxt[i] = srt_mode_s'(PWDATA_I[7:0]);
      end
      wr_cnt  = wr_en && dec.hit_count && dec.idx == 3'(i);
      // a reload coinciding with a write already takes the new value
      rld_eff = wr_cnt ? PWDATA_I[SRT_CNT_W-1:0] : rld_r[i];
      rld_nxt[i] = rld_eff;
      if (wr_cnt && !start_r[i]) begin
        cnt_nxt[i] = PWDATA_I[SRT_CNT_W-1:0];
      end
      tick = 1'b0;
      up   = 1'b0;
      unique case (mode_r[i].mode)
        SRT_MODE_TIMER: begin
          tick = src_tick[mode_r[i].src];
          if (mode_r[i].opt_a && in_s2_r[i] != mode_r[i].opt_b) begin
            tick = 1'b0;
          end
        end
        SRT_MODE_EVENT: begin
          unique case (mode_r[i].src)
            SRT_SRC_0: tick = mode_r[i].edge_rise ? (in_s2_r[i] & ~in_prev_r[i])
                                                  : (~in_s2_r[i] & in_prev_r[i]);
            SRT_SRC_1: tick = (i < NUM_TIMERS / 2) ? SECOND_GROUP_TIMER_TWO_OVF_I
                                                   : SECOND_GROUP_TIMER_FIVE_OVF_I;
            SRT_SRC_2: tick = wrap_r[(i + NUM_TIMERS - 1) % NUM_TIMERS];
            SRT_SRC_3: tick = wrap_r[(i + 1) % NUM_TIMERS];
          endcase
          up = mode_r[i].opt_a ? out_s2_r[i] : dir_r[i];
        end
        // one-shot and pwm are not carried by this block: counter holds
        SRT_MODE_ONESH,
        SRT_MODE_PWM: tick = 1'b0;
      endcase
      if (start_r[i] && tick) begin
        limit = up ? (cnt_r[i] == SRT_COUNT_TOP) : (cnt_r[i] == SRT_COUNT_RST);
        if (!limit) begin
          cnt_nxt[i] = up ? cnt_r[i] + 16'h0001 : cnt_r[i] - 16'h0001;
        end else begin
          wrap_nxt[i] = 1'b1;
          if (mode_r[i].mode == SRT_MODE_EVENT && mode_r[i].opt_b) begin
            cnt_nxt[i] = up ? SRT_COUNT_RST : SRT_COUNT_TOP;
          end else begin
            cnt_nxt[i] = rld_eff;
          end
          if (mode_r[i].pulse_en) begin
            pout_nxt[i] = ~pout_r[i];
          end
        end
      end
      oe_nxt[i] = mode_r[i].pulse_en &&
                  !(mode_r[i].mode == SRT_MODE_EVENT && mode_r[i].opt_a);
    end
    // every timer uses the single-phase path
  end

  // apb read data captured in the setup cycle
  always_comb begin
    rdata_nxt = rdata_r;
    err_nxt   = err_r;
    if (PSEL_I && !PENABLE_I) begin
      rdata_nxt = '0;
      err_nxt   = 1'b0;
      if (dec.hit_start) begin
        rdata_nxt[NUM_TIMERS-1:0] = start_r;
      end else if (dec.hit_dir) begin
        rdata_nxt[NUM_TIMERS-1:0] = dir_r;
      end else if (dec.hit_mode) begin
        rdata_nxt[7:0] = mode_r[dec.idx];
      end else if (dec.hit_count) begin
        rdata_nxt[SRT_CNT_W-1:0] = cnt_r[dec.idx];
      end else begin
        err_nxt = 1'b1; // unmapped address
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      start_r <= SRT_START_RST;
      dir_r   <= SRT_DIR_RST;
      wrap_r  <= '0;
      pout_r  <= '0;
      oe_r    <= '0;
      rdata_r <= '0;
      err_r   <= 1'b0;
      for (int i = 0; i < NUM_TIMERS; i++) begin
        mode_r[i] <= srt_mode_s'(SRT_MODE_RST);
        cnt_r[i]  <= SRT_COUNT_RST;
        rld_r[i]  <= SRT_COUNT_RST;
      end
    end else begin
      start_r <= start_nxt;
      dir_r   <= dir_nxt;
      wrap_r  <= wrap_nxt;
      pout_r  <= pout_nxt;
      oe_r    <= oe_nxt;
      rdata_r <= rdata_nxt;
      err_r   <= err_nxt;
      for (int i = 0; i < NUM_TIMERS; i++) begin
        mode_r[i] <= mode_nxt[i];
        cnt_r[i]  <= cnt_nxt[i];
        rld_r[i]  <= rld_nxt[i];
      end
    end
  end

  // outputs; zero-wait apb answer, data already registered
  assign PREADY_O              = 1'b1;
  assign PRDATA_O              = rdata_r;
  assign PSLVERR_O             = err_r & PSEL_I & PENABLE_I;
  assign TIMER_OUTPUT_PIN_O    = pout_r;
  assign TIMER_OUTPUT_PIN_OE_O = oe_r;
  assign TIMER_IRQ_O           = wrap_r;

endmodule // srt_timer_group

// *** common/srt_pkg.sv ***
// constants, types and register map of the reload timer group
package srt_pkg;

  // group geometry
  localparam int SRT_NUM_TIMERS = 8;
  localparam int SRT_CNT_W      = 16;
  localparam int SRT_ADDR_W     = 12;

  // register byte offsets, one aligned 32-bit word each
  localparam logic [11:0] SRT_START_OFS    = 12'h000;
  localparam logic [11:0] SRT_DIR_OFS      = 12'h004;
  localparam logic [11:0] SRT_MODE_BASE    = 12'h010;
  localparam logic [11:0] SRT_COUNT_BASE   = 12'h014;
  localparam logic [11:0] SRT_TIMER_STRIDE = 12'h008;

  // reset values and the up-count limit
  localparam logic [7:0]  SRT_START_RST = 8'h00;
  localparam logic [7:0]  SRT_DIR_RST   = 8'h00;
  localparam logic [7:0]  SRT_MODE_RST  = 8'h00;
  localparam logic [15:0] SRT_COUNT_RST = 16'h0000;
  localparam logic [15:0] SRT_COUNT_TOP = 16'hffff;

  // prescaler terminal counts (divide by eight and by thirty-two)
  localparam logic [4:0] SRT_DIV8_MASK  = 5'h07;
  localparam logic [4:0] SRT_DIV32_LAST = 5'h1f;

  // operating mode, mode register bits 1:0
  typedef enum logic [1:0] {
    SRT_MODE_TIMER = 2'h0,
    SRT_MODE_EVENT = 2'h1,
    SRT_MODE_ONESH = 2'h2,
    SRT_MODE_PWM   = 2'h3
  } srt_mode_e;

  // count source, mode register bits 7:6 (meaning depends on mode)
  localparam logic [1:0] SRT_SRC_0 = 2'h0; // undivided clock / input pin edge
  localparam logic [1:0] SRT_SRC_1 = 2'h1; // clock div 8 / second group overflow
  localparam logic [1:0] SRT_SRC_2 = 2'h2; // clock div 32 / neighbour first
  localparam logic [1:0] SRT_SRC_3 = 2'h3; // subclock div 32 / neighbour second

  // timer_mode_select_reg layout, low bit last
  typedef struct packed {
    logic [1:0] src;        // count source
    logic       edge_rise;  // event: 1 counts rising input edges
    logic       opt_b;      // timer: gate active level; event: free-run
    logic       opt_a;      // timer: gate enable; event: direction from pin
    logic       pulse_en;   // drive pulse output on the output pin
    srt_mode_e  mode;       // operating mode
  } srt_mode_s;

  // decoded apb address
  typedef struct packed {
    logic       hit_start;
    logic       hit_dir;
    logic       hit_mode;
    logic       hit_count;
    logic [2:0] idx;
  } srt_dec_s;

endpackage

// *** test/srt_timer_group_assertions.sv ***
// port checker for the reload timer group
`timescale 1ns/1ps
module srt_checker
  import srt_pkg::*;
#(
  parameter int NUM_TIMERS = SRT_NUM_TIMERS
) (
  input wire logic                  CLK_I,
  input wire logic                  RESET_I,
  input wire logic                  PSEL_I,
  input wire logic                  PENABLE_I,
  input wire logic                  PWRITE_I,
  input wire logic [SRT_ADDR_W-1:0] PADDR_I,
  input wire logic [31:0]           PWDATA_I,
  input wire logic [31:0]           PRDATA_O,
  input wire logic                  PREADY_O,
  input wire logic                  PSLVERR_O,
  input wire logic [NUM_TIMERS-1:0] TIMER_OUTPUT_PIN_O,
  input wire logic [NUM_TIMERS-1:0] TIMER_OUTPUT_PIN_OE_O,
  input wire logic [NUM_TIMERS-1:0] TIMER_IRQ_O
);
  logic [NUM_TIMERS-1:0] st_r;
  logic [7:0]            dir_r;
  wire                   wr_acc = PSEL_I && PENABLE_I && PWRITE_I;
  wire                   rd_acc = PSEL_I && PENABLE_I && !PWRITE_I;
  // shadow start and direction words, updated at the write edge
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      st_r <= '0;
      dir_r <= '0;
    end else if (wr_acc && PADDR_I == SRT_START_OFS) begin
      st_r <= PWDATA_I[NUM_TIMERS-1:0];
    end else if (wr_acc && PADDR_I == SRT_DIR_OFS) begin
      dir_r <= PWDATA_I[7:0];
    end
  end
  // word-aligned start, direction and per-timer pairs only
  function automatic logic mapped(input logic [11:0] a);
    return a[1:0] == 2'h0 && (a <= SRT_DIR_OFS || (a >= SRT_MODE_BASE && a <= 12'h04c));
  endfunction
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  property p_ready; PREADY_O; endproperty
  property p_err; PSEL_I && PENABLE_I |-> PSLVERR_O == !mapped(PADDR_I); endproperty
  property p_noerr; !(PSEL_I && PENABLE_I) |-> !PSLVERR_O; endproperty
  property p_rd_st; rd_acc && PADDR_I == SRT_START_OFS |-> PRDATA_O == 32'(st_r); endproperty
  property p_rd_dir; rd_acc && PADDR_I == SRT_DIR_OFS |-> PRDATA_O == 32'(dir_r); endproperty
  // a halted timer may still finish the pulse of its last wrap
  property p_irq_run; (TIMER_IRQ_O & ~(st_r | $past(st_r) | $past(st_r, 2))) == '0; endproperty
  property p_tog;
    ((TIMER_OUTPUT_PIN_O ^ $past(TIMER_OUTPUT_PIN_O)) & TIMER_OUTPUT_PIN_OE_O
      & $past(TIMER_OUTPUT_PIN_OE_O)) == (TIMER_IRQ_O & TIMER_OUTPUT_PIN_OE_O);
  endproperty
  property p_rst;
    $past(RESET_I) |-> (TIMER_IRQ_O | TIMER_OUTPUT_PIN_O | TIMER_OUTPUT_PIN_OE_O) == '0;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  a_err: assert property (p_err) else $error("slave error wrong");
  a_noerr: assert property (p_noerr) else $error("error outside access");
  a_rd_st: assert property (p_rd_st) else $error("start readback wrong");
  a_rd_dir: assert property (p_rd_dir) else $error("direction readback wrong");
  a_irq_run: assert property (p_irq_run) else $error("request from halted timer");
  a_tog: assert property (p_tog) else $error("output toggle without wrap");
  a_rst: assert property (p_rst) else $error("outputs not cleared");
  c_irq: cover property (TIMER_IRQ_O[0]);
  c_err: cover property (PSLVERR_O);
  c_ev: cover property (TIMER_IRQ_O[3]);
endmodule // srt_checker
bind srt_timer_group srt_checker #(.NUM_TIMERS(NUM_TIMERS)) u_chk (.CLK_I, .RESET_I,
  .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I, .PRDATA_O, .PREADY_O, .PSLVERR_O,
  .TIMER_OUTPUT_PIN_O, .TIMER_OUTPUT_PIN_OE_O, .TIMER_IRQ_O);

// *** test/srt_pin_model.sv ***
// external gate, count, direction and subclock pins
`timescale 1ns/1ps
module srt_pin_model
  import srt_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic [7:0]  pin_o_i,
  input  wire logic [7:0]  oe_i,
  output logic      [7:0]  in_pin_o,
  output logic      [7:0]  out_pin_o,
  output logic             subclk_o
);
  logic [7:0] dir_lvl;
  // pin level seen by the block: its own drive, else our direction level
  assign out_pin_o = (oe_i & pin_o_i) | (~oe_i & dir_lvl);
  // free oscillator, phase unrelated to the system clock
  initial begin
    in_pin_o = '0;
    dir_lvl = '0;
    subclk_o = 1'b0;
    #7;
    forever #40 subclk_o = ~subclk_o;
  end
  // hold long enough for the pin synchroniser and edge detect
  task automatic set_in(input int i, input logic v);
    @(posedge clk_i);
    in_pin_o[i] <= v;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic pulses(input int i, input int n);
    repeat (n) begin
      set_in(i, 1'b1);
      set_in(i, 1'b0);
    end
  endtask
  task automatic set_dir(input int i, input logic v);
    dir_lvl[i] = v;
  endtask
endmodule // srt_pin_model

// *** test/srt_timer_group_tb.sv ***
// self-checking bench of the reload timer group
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module srt_timer_group_tb
  import srt_pkg::*;
;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, ovf2 = 0, pready, pslverr, subclk;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [7:0] tin, tout, pin_o, oe, irq, pin_q;
  int n_fail = 0, cmp_count = 0, a, nirq[8], ntog[8];
  int dv[4] = '{0, 8, 32, 128};
  always #10 clk = ~clk;
  srt_timer_group u_dut (.CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .SUBCLOCK_I(subclk),
    .SECOND_GROUP_TIMER_TWO_OVF_I(ovf2), .SECOND_GROUP_TIMER_FIVE_OVF_I(1'b0),
    .TIMER_INPUT_PIN_I(tin), .TIMER_OUTPUT_PIN_I(tout), .TIMER_OUTPUT_PIN_O(pin_o),
    .TIMER_OUTPUT_PIN_OE_O(oe), .TIMER_IRQ_O(irq));
  srt_pin_model u_pins (.clk_i(clk), .pin_o_i(pin_o), .oe_i(oe), .in_pin_o(tin),
    .out_pin_o(tout), .subclk_o(subclk));
  // running tallies of request pulses and output toggles
  always @(posedge clk) begin
    pin_q <= pin_o;
    for (int i = 0; i < 8; i++) begin
      if (irq[i] === 1'b1) nirq[i]++;
      if (pin_o[i] !== pin_q[i]) ntog[i]++;
    end
  end
  function automatic logic [11:0] ma(input int i);
    return SRT_MODE_BASE + SRT_TIMER_STRIDE * 12'(i);
  endfunction
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d,
                     output logic [31:0] q);
    int k;
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    k = 0;
    do @(posedge clk); while (pready !== 1'b1 && ++k < 50);
    q = prdata;
    psel <= 0;
    pen <= 0;
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, ad, d, q);
  endtask
  task automatic rd(input logic [11:0] ad, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, ad, '0, q);
    `CHK(q, e)
  endtask
  // settle one period plus margin first, so the window sees steady state
  task automatic cnt(input int i, input int cyc, input int e);
    int b;
    repeat (cyc / 10 + 10) @(posedge clk);
    a = nirq[i];
    b = ntog[i];
    repeat (cyc) @(posedge clk);
    `CHK(nirq[i] - a, e)
    `CHK(ntog[i] - b, e)
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    finish_test();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    rd(SRT_START_OFS, 0);
    rd(SRT_DIR_OFS, 0);
    rd(ma(0) + 12'h004, 0);
    rd(12'h008, 0);
    $display("test reset done");
    wr(ma(0), 32'h04);
    wr(ma(0) + 12'h004, 5);
    rd(ma(0) + 12'h004, 5);
    wr(SRT_START_OFS, 1);
    cnt(0, 60, 10);
    wr(ma(0) + 12'h004, 2);
    cnt(0, 30, 10);
    wr(SRT_START_OFS, 0);
    cnt(0, 30, 0);
    // each prescaled source, reload zero wraps on every tick
    for (int s = 1; s < 4; s++) begin
      wr(ma(0), 32'(s * 64 + 4));
      wr(ma(0) + 12'h004, 0);
      wr(SRT_START_OFS, 1);
      cnt(0, 10 * dv[s], 10);
      wr(SRT_START_OFS, 0);
    end
    wr(ma(0), 32'h1c);
    wr(ma(0) + 12'h004, 1);
    wr(SRT_START_OFS, 1);
    cnt(0, 20, 0);
    u_pins.set_in(0, 1);
    cnt(0, 20, 10);
    $display("test timer mode done");
    wr(SRT_START_OFS, 0);
    wr(ma(1), 32'h25);
    wr(ma(1) + 12'h004, 3);
    wr(SRT_START_OFS, 2);
    a = nirq[1];
    u_pins.pulses(1, 8);
    `CHK(nirq[1] - a, 2)
    wr(SRT_START_OFS, 0);
    wr(SRT_DIR_OFS, 2);
    wr(ma(1) + 12'h004, 16'hfffd);
    wr(SRT_START_OFS, 2);
    a = nirq[1];
    u_pins.pulses(1, 9);
    `CHK(nirq[1] - a, 3)
    wr(SRT_START_OFS, 0);
    wr(ma(1), 32'h35);
    wr(ma(1) + 12'h004, 16'hfffd);
    wr(SRT_START_OFS, 2);
    a = nirq[1];
    u_pins.pulses(1, 6);
    `CHK(nirq[1] - a, 1)
    rd(ma(1) + 12'h004, 3);
    wr(SRT_START_OFS, 0);
    wr(ma(1), 32'h09);
    wr(ma(1) + 12'h004, 10);
    wr(SRT_START_OFS, 2);
    u_pins.set_dir(1, 1);
    u_pins.set_in(1, 1);
    rd(ma(1) + 12'h004, 10);
    u_pins.set_in(1, 0);
    rd(ma(1) + 12'h004, 11);
    u_pins.set_dir(1, 0);
    u_pins.pulses(1, 1);
    rd(ma(1) + 12'h004, 10);
    // second-group overflow feeds timer 2, whose wraps feed timer 3
    wr(ma(2), 32'h45);
    wr(ma(3), 32'h85);
    wr(SRT_START_OFS, 32'h0c);
    a = nirq[2] + nirq[3];
    repeat (2) begin
      @(posedge clk);
      ovf2 <= 1;
      @(posedge clk);
      ovf2 <= 0;
      repeat (4) @(posedge clk);
    end
    `CHK(nirq[2] + nirq[3] - a, 4)
    $display("test event mode done");
    finish_test();
  end
endmodule // srt_timer_group_tb
